// >>> vidss_pkg.sv
// Shared constants for the voltage-ID serial slave and its bus master
package vidss_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int RAMP_HZ = 4_000_000;
  localparam int RAMP_CYC = CLK_HZ / RAMP_HZ;
  localparam int SLOW_DIV = 4;
  localparam int READY_US = 1600;
  localparam int READY_CYC = READY_US * (CLK_HZ / 1_000_000);
  localparam int BUS_MAX_HZ = 26_250_000;
  localparam int SCLK_HALF = 8;
  localparam int TEMP_REF_MV = 900;
  localparam int TEMP_REF_CODE = 100;
  localparam int HYST_PCT = 3;
  localparam logic [3:0] ADDR_MAX_STRAP = 4'hd;
  localparam logic [3:0] ADDR_BCAST_LO = 4'he;
  localparam int HDR_BITS = 15;
  localparam int RD_BITS = 8;
  typedef enum logic [2:0] {
    CMD_SET_TARGET_FAST = 3'h1,
    CMD_SET_TARGET_SLOW = 3'h2,
    CMD_SET_TARGET_UNRAMPED = 3'h3,
    CMD_SET_POWER_STATE = 3'h4,
    CMD_LOAD_TABLE_POINTER = 3'h5,
    CMD_WRITE_POINTED_REGISTER = 3'h6,
    CMD_READ_INDEXED_REGISTER = 3'h7
  } vidss_cmd_e;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_TZONE = 8'h12;
  localparam logic [7:0] REG_VR_TEMP = 8'h17;
  localparam logic [7:0] REG_TRIP_POINT_STRAP = 8'h22;
  localparam logic [7:0] REG_BOOT = 8'h26;
  localparam logic [7:0] REG_VOUT_MAX = 8'h30;
  localparam logic [7:0] REG_VID = 8'h31;
  localparam logic [7:0] REG_PWR = 8'h32;
  localparam logic [7:0] REG_OFFSET = 8'h33;
  localparam logic [7:0] REG_MULTI = 8'h34;
  localparam logic [7:0] REG_PTR = 8'h35;
  localparam logic [7:0] BOOT_CODE = 8'h7e;
  localparam logic [7:0] TRIP_POINT_STRAP_RESET = 8'h96;
  localparam logic [7:0] VOUT_MAX_RESET = 8'hff;
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
endpackage

// >>> vidss_if.sv
// Three-wire management bus joining master and slave
`timescale 1ns/1ps
interface vidss_if;
  logic sclk_o;
  logic sclk_oe_n;
  logic m_sdio_o;
  logic m_sdio_oe_n;
  logic s_sdio_o;
  logic s_sdio_oe_n;
  logic alert_n;
  logic sclk;
  logic sdio;
  // Open-drain wires idle high through the pull-up
  assign sclk = sclk_oe_n | sclk_o;
  assign sdio = (m_sdio_oe_n | m_sdio_o) & (s_sdio_oe_n | s_sdio_o);
  modport master (output sclk_o, output sclk_oe_n, output m_sdio_o, output m_sdio_oe_n,
                  input sdio, input alert_n);
  modport slave (input sclk, input sdio, output s_sdio_o, output s_sdio_oe_n,
                 output alert_n);
endinterface

// >>> vidss_slave.sv
// Voltage-ID serial slave: command decode, code ramp, start-up, thermal flag
`timescale 1ns/1ps
module vidss_slave #(
  parameter int READY_CYC = vidss_pkg::READY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  vidss_if.slave bus,
  input wire logic [11:0] temp_mv_i,
  input wire logic [7:0] addr_strap_i,
  input wire logic [7:0] trip_point_strap_i,
  input wire logic [7:0] vsense_code_i,
  output logic [7:0] voltage_code_o,
  output logic [7:0] power_state_o,
  output logic target_reached_flag_o,
  output logic output_settled_o,
  output logic power_good_o,
  output logic over_temp_flag_n_o,
  output logic over_temp_oe_n_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHIFT = 3'b001,
    ST_ACK = 3'b010,
    ST_ACK_HOLD = 3'b011,
    ST_READ = 3'b100
  } vidss_st_e;

  if (READY_CYC < 1) begin : g_chk
    $error("READY_CYC must be at least one");
  end

  function automatic logic near1(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic sclk_s1, sclk_s2, sclk_s3, sdio_s1, sdio_s2;
  logic [11:0] tmv_s1, tmv_s2;
  logic [7:0] vs_s1, vs_s2, strap_s1, strap_s2, trip_s1, trip_s2;
  always_ff @(posedge clk_i) begin
    sclk_s1 <= bus.sclk;
    sclk_s2 <= sclk_s1;
    sclk_s3 <= sclk_s2;
    sdio_s1 <= bus.sdio;
    sdio_s2 <= sdio_s1;
    tmv_s1 <= temp_mv_i;
    tmv_s2 <= tmv_s1;
    vs_s1 <= vsense_code_i;
    vs_s2 <= vs_s1;
    strap_s1 <= addr_strap_i;
    strap_s2 <= strap_s1;
    trip_s1 <= trip_point_strap_i;
    trip_s2 <= trip_s1;
  end
  logic rise, fall;
  assign rise = sclk_s2 & ~sclk_s3;
  assign fall = ~sclk_s2 & sclk_s3;

  ////////////////////////////////////////////////////////////////////////////
  // State
  vidss_st_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d, addr_q, addr_d;
  logic [13:0] sh_q, sh_d;
  logic [7:0] rd_q, rd_d, vid_q, vid_d, cur_q, cur_d, ps_q, ps_d, ptr_q, ptr_d;
  logic [7:0] vmax_q, vmax_d, offs_q, offs_d, multi_q, multi_d;
  logic [7:0] trip_point_strap_q, trip_point_strap_d, temp_q, temp_d;
  logic sd_q, sd_d, ok_q, ok_d, isrd_q, isrd_d, fast_q, fast_d, decay_q, decay_d;
  logic reached_q, reached_d, settled_q, settled_d, alert_q, alert_d;
  logic pg_q, pg_d, ready_q, ready_d, hot_q, hot_d;
  logic [4:0] tick_q, tick_d;
  logic [1:0] slow_q, slow_d;
  logic [31:0] rdy_q, rdy_d;
  logic [14:0] w;
  logic [3:0] fa;
  logic [2:0] fc;
  logic [7:0] fp, hyst;
  logic mine, bcast, newcmd, aclr, aset, step;
  logic [19:0] tcode;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    sd_d = sd_q;
    ok_d = ok_q;
    isrd_d = isrd_q;
    rd_d = rd_q;
    vid_d = vid_q;
    cur_d = cur_q;
    ps_d = ps_q;
    ptr_d = ptr_q;
    vmax_d = vmax_q;
    offs_d = offs_q;
    multi_d = multi_q;
    fast_d = fast_q;
    decay_d = decay_q;
    addr_d = addr_q;
    trip_point_strap_d = trip_point_strap_q;
    ready_d = ready_q;
    rdy_d = rdy_q;
    newcmd = 1'b0;
    aclr = 1'b0;
    w = {sh_q, sdio_s2};
    fa = w[14:11];
    fc = w[10:8];
    fp = w[7:0];
    mine = (fa == addr_q);
    bcast = (fa >= vidss_pkg::ADDR_BCAST_LO);
    // Start-up timer, strap capture and boot target
    if (!ready_q) begin
      rdy_d = rdy_q + 32'd1;
      if (rdy_q == 32'(READY_CYC - 1)) begin
        ready_d = 1'b1;
        addr_d = (strap_s2[7:4] > vidss_pkg::ADDR_MAX_STRAP) ?
                 vidss_pkg::ADDR_MAX_STRAP : strap_s2[7:4];
        trip_point_strap_d = trip_s2;
        vid_d = vidss_pkg::BOOT_CODE;
        fast_d = 1'b0;
        decay_d = 1'b0;
        newcmd = 1'b1;
      end
    end
    // Frame engine: sample on rising, drive on falling
    unique case (st_q)
      ST_IDLE: begin
        if (rise && !sdio_s2 && ready_q) begin
          st_d = ST_SHIFT;
          cnt_d = 4'd0;
        end
      end
      ST_SHIFT: begin
        if (rise) begin
          sh_d = w[13:0];
          cnt_d = cnt_q + 4'd1;
          if (cnt_q == 4'(vidss_pkg::HDR_BITS - 1)) begin
            st_d = ST_ACK;
            ok_d = 1'b0;
            isrd_d = 1'b0;
            unique case (fc)
              vidss_pkg::CMD_SET_TARGET_FAST, vidss_pkg::CMD_SET_TARGET_SLOW,
              vidss_pkg::CMD_SET_TARGET_UNRAMPED: begin
                if (mine || bcast) begin
                  ok_d = 1'b1;
                  vid_d = (fp > vmax_q) ? vmax_q : fp;
                  newcmd = 1'b1;
                  fast_d = (fc == vidss_pkg::CMD_SET_TARGET_FAST);
                  decay_d = (fc == vidss_pkg::CMD_SET_TARGET_UNRAMPED);
                  if (fc == vidss_pkg::CMD_SET_TARGET_UNRAMPED) begin
                    cur_d = vid_d;
                  end else if (fp > vid_q) begin
                    ps_d = 8'h00;
                  end
                end
              end
              vidss_pkg::CMD_SET_POWER_STATE: begin
                if (mine || bcast) begin
                  ok_d = 1'b1;
                  ps_d = fp;
                end
              end
              vidss_pkg::CMD_LOAD_TABLE_POINTER: begin
                if (mine) begin
                  ok_d = 1'b1;
                  ptr_d = fp;
                end
              end
              vidss_pkg::CMD_WRITE_POINTED_REGISTER: begin
                if (mine) begin
                  ok_d = 1'b1;
                  unique case (ptr_q)
                    vidss_pkg::REG_VOUT_MAX: vmax_d = fp;
                    vidss_pkg::REG_PWR: ps_d = fp;
                    vidss_pkg::REG_OFFSET: offs_d = fp;
                    vidss_pkg::REG_MULTI: multi_d = fp;
                    vidss_pkg::REG_PTR: ptr_d = fp;
                    default: ok_d = 1'b1;
                  endcase
                end
              end
              vidss_pkg::CMD_READ_INDEXED_REGISTER: begin
                if (mine) begin
                  ok_d = 1'b1;
                  isrd_d = 1'b1;
                  aclr = (fp == vidss_pkg::REG_STATUS);
                  unique case (fp)
                    vidss_pkg::REG_STATUS: rd_d = {5'h00, hot_q, pg_q, settled_q};
                    vidss_pkg::REG_TZONE: rd_d = {hot_q, 7'h00};
                    vidss_pkg::REG_VR_TEMP: rd_d = temp_q;
                    vidss_pkg::REG_TRIP_POINT_STRAP: rd_d = trip_point_strap_q;
                    vidss_pkg::REG_BOOT: rd_d = vidss_pkg::BOOT_CODE;
                    vidss_pkg::REG_VOUT_MAX: rd_d = vmax_q;
                    vidss_pkg::REG_VID: rd_d = vid_q;
                    vidss_pkg::REG_PWR: rd_d = ps_q;
                    vidss_pkg::REG_OFFSET: rd_d = offs_q;
                    vidss_pkg::REG_MULTI: rd_d = multi_q;
                    vidss_pkg::REG_PTR: rd_d = ptr_q;
                    default: rd_d = 8'h00;
                  endcase
                end
              end
              default: ok_d = 1'b0;
            endcase
          end
        end
      end
      ST_ACK: begin
        if (fall) begin
          sd_d = ~ok_q;
          st_d = ST_ACK_HOLD;
        end
      end
      ST_ACK_HOLD: begin
        if (rise) begin
          sd_d = 1'b1;
          cnt_d = 4'd0;
          st_d = (ok_q && isrd_q) ? ST_READ : ST_IDLE;
        end
      end
      ST_READ: begin
        if (fall) begin
          sd_d = rd_q[7];
          rd_d = {rd_q[6:0], 1'b0};
        end
        if (rise) begin
          cnt_d = cnt_q + 4'd1;
          if (cnt_q == 4'(vidss_pkg::RD_BITS - 1)) begin
            sd_d = 1'b1;
            st_d = ST_IDLE;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Ramp pacing
    tick_d = (tick_q == 5'(vidss_pkg::RAMP_CYC - 1)) ? 5'd0 : tick_q + 5'd1;
    slow_d = slow_q;
    step = 1'b0;
    if (tick_q == 5'(vidss_pkg::RAMP_CYC - 1)) begin
      slow_d = slow_q + 2'd1;
      step = fast_q || (slow_q == 2'(vidss_pkg::SLOW_DIV - 1));
    end
    if (step && !newcmd && cur_q != vid_q) begin
      cur_d = (cur_q < vid_q) ? cur_q + 8'd1 : cur_q - 8'd1;
    end
    // Reached, settled, alert, power good
    reached_d = (newcmd || !ready_q) ? 1'b0 : (reached_q | near1(cur_q, vid_q));
    settled_d = (newcmd || !ready_q) ? 1'b0 :
                (reached_q && (decay_q || near1(vs_s2, cur_q)));
    aset = settled_d && !settled_q && !decay_q;
    alert_d = aset | (alert_q & ~aclr);
    pg_d = pg_q | aset;
    // Temperature
    tcode = 20'(tmv_s2) * 20'(vidss_pkg::TEMP_REF_CODE) / 20'(vidss_pkg::TEMP_REF_MV);
    temp_d = (tcode > 20'h000ff) ? 8'hff : tcode[7:0];
    hyst = 8'((16'(trip_point_strap_q) * 16'(vidss_pkg::HYST_PCT)) / 16'd100);
    hot_d = hot_q;
    if (temp_q >= trip_point_strap_q) begin
      hot_d = 1'b1;
    end else if (9'(temp_q) + 9'(hyst) < 9'(trip_point_strap_q)) begin
      hot_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'd0;
      sh_q <= 14'h0000;
      sd_q <= 1'b1;
      ok_q <= 1'b0;
      isrd_q <= 1'b0;
      rd_q <= 8'h00;
      vid_q <= 8'h00;
      cur_q <= 8'h00;
      ps_q <= 8'h00;
      ptr_q <= 8'h00;
      vmax_q <= vidss_pkg::VOUT_MAX_RESET;
      offs_q <= 8'h00;
      multi_q <= 8'h00;
      fast_q <= 1'b0;
      decay_q <= 1'b0;
      addr_q <= 4'h0;
      trip_point_strap_q <= vidss_pkg::TRIP_POINT_STRAP_RESET;
      temp_q <= 8'h00;
      ready_q <= 1'b0;
      rdy_q <= 32'd0;
      tick_q <= 5'd0;
      slow_q <= 2'd0;
      reached_q <= 1'b0;
      settled_q <= 1'b0;
      alert_q <= 1'b0;
      pg_q <= 1'b0;
      hot_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      sd_q <= sd_d;
      ok_q <= ok_d;
      isrd_q <= isrd_d;
      rd_q <= rd_d;
      vid_q <= vid_d;
      cur_q <= cur_d;
      ps_q <= ps_d;
      ptr_q <= ptr_d;
      vmax_q <= vmax_d;
      offs_q <= offs_d;
      multi_q <= multi_d;
      fast_q <= fast_d;
      decay_q <= decay_d;
      addr_q <= addr_d;
      trip_point_strap_q <= trip_point_strap_d;
      temp_q <= temp_d;
      ready_q <= ready_d;
      rdy_q <= rdy_d;
      tick_q <= tick_d;
      slow_q <= slow_d;
      reached_q <= reached_d;
      settled_q <= settled_d;
      alert_q <= alert_d;
      pg_q <= pg_d;
      hot_q <= hot_d;
    end
  end

  assign bus.s_sdio_o = sd_q;
  assign bus.s_sdio_oe_n = sd_q;
  assign bus.alert_n = ~alert_q;
  assign voltage_code_o = cur_q;
  assign power_state_o = ps_q;
  assign target_reached_flag_o = reached_q;
  assign output_settled_o = settled_q;
  assign power_good_o = pg_q;
  assign over_temp_flag_n_o = ~hot_q;
  assign over_temp_oe_n_o = ~hot_q;
endmodule // vidss_slave

// >>> vidss_master.sv
// Bus master end: Wishbone command registers to serial frames
`timescale 1ns/1ps
module vidss_master #(
  parameter int SCLK_HALF = vidss_pkg::SCLK_HALF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  vidss_if.master bus,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef enum logic [1:0] {
    HM_IDLE = 2'b00,
    HM_SEND = 2'b01,
    HM_ACK = 2'b10,
    HM_READ = 2'b11
  } vidss_hm_e;

  if (SCLK_HALF < 7 || SCLK_HALF > 256 ||
      vidss_pkg::CLK_HZ / (2 * SCLK_HALF) > vidss_pkg::BUS_MAX_HZ) begin : g_chk
    $error("SCLK_HALF out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic sd_s1, sd_s2, al_s1, al_s2;
  always_ff @(posedge clk_i) begin
    sd_s1 <= bus.sdio;
    sd_s2 <= sd_s1;
    al_s1 <= bus.alert_n;
    al_s2 <= al_s1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer and register slave
  vidss_hm_e st_q, st_d;
  logic [7:0] ph_q, ph_d;
  logic [4:0] bit_q, bit_d;
  logic [15:0] sh_q, sh_d;
  logic [7:0] rd_q, rd_d;
  logic sclk_q, sclk_d, sd_q, sd_d, isrd_q, isrd_d, acked_q, acked_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic hit, last_ph;

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rd_d = rd_q;
    sclk_d = sclk_q;
    sd_d = sd_q;
    isrd_d = isrd_q;
    acked_d = acked_q;
    hit = wb_cyc_i && wb_stb_i && !ack_q;
    ack_d = hit;
    dat_d = 32'h0000_0000;
    if (hit && !wb_we_i && wb_adr_i == vidss_pkg::WB_STAT) begin
      dat_d = {16'h0000, rd_q, 5'h00, ~al_s2, acked_q, (st_q != HM_IDLE)};
    end
    last_ph = (ph_q == 8'(SCLK_HALF - 1));
    ph_d = last_ph ? 8'd0 : ph_q + 8'd1;
    unique case (st_q)
      HM_IDLE: begin
        ph_d = 8'd0;
        sclk_d = 1'b1;
        sd_d = 1'b1;
        if (hit && wb_we_i && wb_adr_i == vidss_pkg::WB_CMD && wb_sel_i[1:0] == 2'b11) begin
          sh_d = {1'b0, wb_dat_i[3:0], wb_dat_i[6:4], wb_dat_i[15:8]};
          isrd_d = (wb_dat_i[6:4] == vidss_pkg::CMD_READ_INDEXED_REGISTER);
          acked_d = 1'b0;
          bit_d = 5'd0;
          sclk_d = 1'b0;
          sd_d = 1'b0;
          st_d = HM_SEND;
        end
      end
      HM_SEND: begin
        if (last_ph) begin
          sclk_d = ~sclk_q;
          if (sclk_q) begin
            bit_d = bit_q + 5'd1;
            sh_d = {sh_q[14:0], 1'b1};
            sd_d = sh_q[14];
            if (bit_q == 5'(vidss_pkg::HDR_BITS)) begin
              sd_d = 1'b1;
              st_d = HM_ACK;
            end
          end
        end
      end
      HM_ACK: begin
        if (last_ph) begin
          if (!sclk_q) begin
            sclk_d = 1'b1;
            acked_d = ~sd_s2;
            bit_d = 5'd0;
          end else if (isrd_q && acked_q) begin
            sclk_d = 1'b0;
            st_d = HM_READ;
          end else begin
            st_d = HM_IDLE;
          end
        end
      end
      HM_READ: begin
        if (last_ph) begin
          sclk_d = ~sclk_q;
          if (!sclk_q) begin
            rd_d = {rd_q[6:0], sd_s2};
            bit_d = bit_q + 5'd1;
          end else if (bit_q == 5'(vidss_pkg::RD_BITS)) begin
            sclk_d = 1'b1;
            st_d = HM_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= HM_IDLE;
      ph_q <= 8'd0;
      bit_q <= 5'd0;
      sh_q <= 16'hffff;
      rd_q <= 8'h00;
      sclk_q <= 1'b1;
      sd_q <= 1'b1;
      isrd_q <= 1'b0;
      acked_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      sclk_q <= sclk_d;
      sd_q <= sd_d;
      isrd_q <= isrd_d;
      acked_q <= acked_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign bus.sclk_o = sclk_q;
  assign bus.sclk_oe_n = sclk_q;
  assign bus.m_sdio_o = sd_q;
  assign bus.m_sdio_oe_n = sd_q;
  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
endmodule // vidss_master

// >>> vidss_checker.sv
// Assertions on the three-wire bus between master and slave
`timescale 1ns/1ps
module vidss_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_o,
  input wire logic sclk_oe_n,
  input wire logic m_sdio_o,
  input wire logic m_sdio_oe_n,
  input wire logic s_sdio_o,
  input wire logic s_sdio_oe_n,
  input wire logic alert_n,
  input wire logic sclk,
  input wire logic sdio
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  chk_sclk_drain: assert property (!sclk_oe_n |-> !sclk_o)
    else $error("clock driven high");
  chk_mdata_low: assert property ($changed(m_sdio_oe_n) |-> !sclk)
    else $error("master data changed while clock high");
  chk_sdata_hold: assert property ($rose(sclk) |-> $stable(s_sdio_oe_n))
    else $error("slave data changed at clock rise");
  chk_sclk_low: assert property ($fell(sclk) |-> !sclk [*7])
    else $error("clock low phase too short");
  chk_sclk_high: assert property ($rose(sclk) |-> sclk [*7])
    else $error("clock high phase too short");
  chk_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> sclk_oe_n && m_sdio_oe_n && s_sdio_oe_n && alert_n)
    else $error("bus not released in reset");
  chk_slave_turn: assert property ($fell(s_sdio_oe_n) |-> !sclk)
    else $error("slave drives during clock high");
  chk_no_clash: assert property (!s_sdio_oe_n |-> m_sdio_oe_n)
    else $error("both ends drive data");
  chk_alert_hold: assert property ($fell(alert_n) |=> !alert_n [*8])
    else $error("alert not held");
  ////////////////////////////////////////////////////////////////////////////////
  cov_alert: cover property ($fell(alert_n));
  cov_alert_clear: cover property ($rose(alert_n));
  cov_slave_drive: cover property ($fell(s_sdio_oe_n));
endmodule // vidss_checker

// >>> test_voltage_id_serial_slave.sv
// Self-checking bench: master and slave joined over the serial bus
`timescale 1ns/1ps
module test_voltage_id_serial_slave;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, chk_q = 1'b0, ack;
  logic reached, settled, pg, hot_n, hot_oe_n;
  logic [7:0] adr = 8'h00, strap = 8'h30, vs = 8'h00, code, ps;
  logic [11:0] temp = 12'h000;
  logic [31:0] wdat = 32'h0, rdat, q, e;
  logic [14:0] nk [6] = '{{4'he, 3'h5, 8'h33}, {4'hf, 3'h6, 8'h00}, {4'he, 3'h7, 8'h10},
                         {4'h4, 3'h1, 8'h10}, {4'h4, 3'h7, 8'h10}, {4'h3, 3'h0, 8'h00}};
  int bad_count = 0, samples_checked = 0, seed = 32'h209bce13, n, tv;
  logic [31:0] exp_q [$];
  vidss_if bus_if();
  vidss_master vidss_master_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if.master),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack));
  vidss_slave #(.READY_CYC(200)) vidss_slave_inst (.clk_i(clk_i), .rst_i(rst_i),
    .bus(bus_if.slave), .temp_mv_i(temp), .addr_strap_i(strap), .trip_point_strap_i(8'h96),
    .vsense_code_i(vs), .voltage_code_o(code), .power_state_o(ps),
    .target_reached_flag_o(reached), .output_settled_o(settled), .power_good_o(pg),
    .over_temp_flag_n_o(hot_n), .over_temp_oe_n_o(hot_oe_n));
  vidss_checker vidss_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .sclk_o(bus_if.sclk_o),
    .sclk_oe_n(bus_if.sclk_oe_n), .m_sdio_o(bus_if.m_sdio_o), .m_sdio_oe_n(bus_if.m_sdio_oe_n),
    .s_sdio_o(bus_if.s_sdio_o), .s_sdio_oe_n(bus_if.s_sdio_oe_n), .alert_n(bus_if.alert_n),
    .sclk(bus_if.sclk), .sdio(bus_if.sdio));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) vs <= code;
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp({15'h0, got}, {15'h0, exp});
  endtask
  task automatic tmo();
    $display("unexpected at %0t: wait ran out", $time);
    bad_count++;
    summarize();
  endtask
  // Status reads marked for checking are compared here as the answer lands
  always @(posedge clk_i) begin
    if (ack === 1'b1 && chk_q) begin
      e = exp_q.pop_front();
      cmp(rdat[15:0] & e[31:16], e[15:0]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    chk_q <= c;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (i == 50) tmo();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk_q <= 1'b0;
  endtask
  task automatic send(input logic [3:0] a, input logic [2:0] c, input logic [7:0] p);
    int i;
    wb(1'b1, vidss_pkg::WB_CMD, {16'h0, p, 1'b0, c, a}, 1'b0);
    for (i = 0; i < 400; i++) begin
      wb(1'b0, vidss_pkg::WB_STAT, 32'h0, 1'b0);
      if (q[0] === 1'b0) break;
    end
    if (i == 400) tmo();
  endtask
  task automatic stat(input logic [15:0] m, input logic [15:0] x);
    exp_q.push_back({m, x & m});
    wb(1'b0, vidss_pkg::WB_STAT, 32'h0, 1'b1);
  endtask
  task automatic ramp(input logic [7:0] t, input int lo, input int hi);
    for (n = 0; n < 1000 && code !== t; n++) @(posedge clk_i);
    if (n == 1000) tmo();
    cmp1(n >= lo && n <= hi, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    tmo();
  end
  initial begin
    strap <= {4'h3, 4'($random(seed))};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmp1(pg, 1'b0);
    for (n = 0; n < 20000 && pg !== 1'b1; n++) @(posedge clk_i);
    if (n == 20000) tmo();
    // Settling may come one step before the last code
    for (n = 0; n < 200 && code !== vidss_pkg::BOOT_CODE; n++) @(posedge clk_i);
    if (n == 200) tmo();
    cmp({8'h0, code}, {8'h0, vidss_pkg::BOOT_CODE});
    cmp1(settled, 1'b1);
    cmp1(bus_if.alert_n, 1'b0);
    $display("test start-up done");
    send(4'h3, 3'h7, vidss_pkg::REG_STATUS);
    stat(16'hff02, 16'h0302);
    cmp1(bus_if.alert_n, 1'b1);
    $display("test alert done");
    send(4'he, 3'h1, 8'h70);
    cmp1(reached, 1'b0);
    ramp(8'h70, 250, 360);
    send(4'hf, 3'h4, 8'h02);
    cmp({8'h0, ps}, 16'h0002);
    send(4'h3, 3'h2, 8'h74);
    cmp({8'h0, ps}, 16'h0000);
    ramp(8'h74, 260, 400);
    cmp1(reached, 1'b1);
    $display("test ramps done");
    send(4'h3, 3'h7, vidss_pkg::REG_STATUS);
    stat(16'hff02, 16'h0302);
    send(4'h3, 3'h3, 8'h40);
    cmp({8'h0, code}, 16'h0040);
    cmp1(settled, 1'b1);
    cmp1(bus_if.alert_n, 1'b1);
    $display("test unramped done");
    foreach (nk[i]) begin
      send(nk[i][14:11], nk[i][10:8], nk[i][7:0]);
      stat(16'h0002, 16'h0000);
    end
    cmp({8'h0, code}, 16'h0040);
    send(4'h3, 3'h4, 8'h03);
    cmp({8'h0, ps}, 16'h0003);
    send(4'h3, 3'h1, 8'h41);
    cmp({8'h0, ps}, 16'h0000);
    send(4'h3, 3'h5, vidss_pkg::REG_OFFSET);
    stat(16'h0002, 16'h0002);
    for (int i = 0; i < 2; i++) begin
      tv = $random(seed) & 255;
      send(4'h3, 3'h6, 8'(tv));
      send(4'h3, 3'h7, vidss_pkg::REG_OFFSET);
      stat(16'hff02, {8'(tv), 8'h02});
    end
    $display("test addressing done");
    tv = 1400 + ($random(seed) & 511);
    temp <= 12'(tv);
    send(4'h3, 3'h7, vidss_pkg::REG_VR_TEMP);
    stat(16'hff02, {8'(tv * 100 / 900), 8'h02});
    cmp1(hot_n, 1'b0);
    cmp1(hot_oe_n, 1'b0);
    temp <= 12'd1330;
    send(4'h3, 3'h7, vidss_pkg::REG_TZONE);
    stat(16'h8002, 16'h8002);
    temp <= 12'd1200;
    send(4'h3, 3'h7, vidss_pkg::REG_TZONE);
    stat(16'h8002, 16'h0002);
    cmp1(hot_n, 1'b1);
    cmp1(hot_oe_n, 1'b1);
    $display("test temperature done");
    summarize();
  end
endmodule // test_voltage_id_serial_slave
